/* core/sysio_pkg.sv */
// Package: offsets, fields, reset values and types of the system IO bank.
// Assumes a classic Wishbone slave with 32-bit data, one register per word.
package sysio_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_FLAGS = 8'h00;
  localparam logic [7:0] IDX_STACK = 8'h02;
  localparam logic [7:0] IDX_CLKMODE = 8'h03;
  localparam logic [7:0] IDX_INTEN = 8'h04;
  localparam logic [7:0] IDX_INTREQ = 8'h05;
  localparam logic [7:0] IDX_WTMODE = 8'h06;
  localparam logic [7:0] IDX_BTABOUND = 8'h09;
  localparam logic [7:0] IDX_XOSC = 8'h0A;
  localparam logic [7:0] IDX_EDGESEL = 8'h0C;
  localparam logic [7:0] IDX_PADIE = 8'h0D;
  localparam logic [7:0] IDX_PBDIE = 8'h0E;
  localparam logic [7:0] IDX_WTCOUNT = 8'h0F;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_STACK = 8'h00;
  localparam logic [7:0] RST_CLKMODE = 8'hF6;
  localparam logic [7:0] RST_INTEN = 8'h00;
  localparam logic [7:0] RST_INTREQ = 8'h00;
  localparam logic [7:0] RST_WTMODE = 8'h00;
  localparam logic [7:0] RST_BTABOUND = 8'h00;
  localparam logic [7:0] RST_XOSC = 8'h00;
  localparam logic [7:0] RST_EDGESEL = 8'h00;
  localparam logic [7:0] RST_PADIE = 8'hF9;
  localparam logic [7:0] RST_PBDIE = 8'hFF;

  // ************************************************************
  // Field positions and masks
  // ************************************************************
  localparam int FLAG_WRAP = 3;
  localparam int FLAG_NIBBLE = 2;
  localparam int FLAG_CARRY = 1;
  localparam int FLAG_ZERO = 0;
  localparam int CM_FAST_EN = 4;
  localparam int CM_TYPE = 3;
  localparam int CM_SLOW_EN = 2;
  localparam int CM_WDOG_EN = 1;
  localparam int CM_PIN_SEL = 0;
  localparam int IRQ_BTB = 7;
  localparam int IRQ_BTA = 6;
  localparam int IRQ_CMP = 4;
  localparam int IRQ_ADC = 3;
  localparam int IRQ_WT = 2;
  localparam int IRQ_PIN2 = 1;
  localparam int IRQ_PIN1 = 0;
  localparam logic [7:0] IRQ_MASK = 8'hDF;
  localparam logic [7:0] FLAG_MASK = 8'h0F;
  localparam logic [7:0] XOSC_MASK = 8'hE1;
  localparam logic [7:0] EDGE_MASK = 8'h1F;
  localparam logic [7:0] PADIE_MASK = 8'hF9;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    CLK_NONE, CLK_FAST_D2, CLK_FAST_D4, CLK_FAST_D8, CLK_FAST_D16,
    CLK_FAST_D32, CLK_FAST_D64, CLK_XTAL_D1, CLK_XTAL_D2, CLK_XTAL_D4,
    CLK_XTAL_D8, CLK_SLOW_D1, CLK_SLOW_D4, CLK_SLOW_D16
  } clkSel_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [9:0] adr;
    logic [31:0] dat;
  } wbReq_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wbRsp_t;

  // Flag update from the arithmetic unit: per-flag write strobe and value
  typedef struct packed {
    logic [3:0] upd;
    logic [3:0] val;
  } aluFlags_t;

  typedef struct packed {
    logic fastOscEn;
    logic slowOscEn;
    logic xtalOscEn;
    logic [1:0] xtalDrive;
    logic refPowerDown;
    logic wdogRun;
    logic resetPinSel;
    clkSel_t clkSel;
  } sysCtl_t;

endpackage

/* core/sys_io_regs.sv */
// System IO register bank: flags, stack pointer, clock mode, interrupts,
// wide timer, oscillator and digital-input enables.
// Assumes pins and tick inputs synchronous to sys_clk; one Wishbone master.
`timescale 1ns/1ps

module sys_io_regs (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire sysio_pkg::wbReq_t wbReq,
  output sysio_pkg::wbRsp_t wbRsp,
  input wire sysio_pkg::aluFlags_t aluFlags,
  input wire logic [7:0] stackIn,
  input wire logic stackLoad,
  output logic [7:0] stackPtr,
  output logic [3:0] flagsOut,
  input wire logic [7:0] portA,
  input wire logic [7:0] portB,
  input wire logic fastTick,
  input wire logic xtalTick,
  input wire logic slowTick,
  input wire logic btaEvent,
  input wire logic btbEvent,
  input wire logic cmpEvent,
  input wire logic adcEvent,
  output sysio_pkg::sysCtl_t sysCtl,
  output logic [7:0] portADigEn,
  output logic [7:0] portBDigEn,
  output logic [7:0] portAWake,
  output logic [7:0] portBWake,
  output logic [7:0] btaBound,
  output logic [15:0] wideCount,
  output logic irq
);
  import sysio_pkg::*;

  // ************************************************************
  // Bus slave
  // ************************************************************
  logic [7:0] flags_q, stack_q, clkMode_q, intEn_q, intReq_q, wtMode_q;
  logic [7:0] btaBound_q, xosc_q, edgeSel_q, padie_q, pbdie_q;
  logic [15:0] count_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] idx;
  logic wrStb;
  logic [7:0] wdat;

  // Byte lane 0 carries every register; writes without it are dropped
  assign idx = wbReq.adr[9:2];
  assign wrStb = wbReq.cyc & wbReq.stb & wbReq.we & wbReq.sel[0] & ~ack_q;
  assign wdat = wbReq.dat[7:0];

  function automatic logic wr(input logic [7:0] i);
    wr = wrStb && (idx == i);
  endfunction

  // Write-only registers read back as zero, unmapped words too
  function automatic logic [7:0] rdMux(input logic [7:0] i);
    unique case (i)
      IDX_FLAGS: rdMux = flags_q;
      IDX_STACK: rdMux = stack_q;
      IDX_CLKMODE: rdMux = clkMode_q;
      IDX_INTEN: rdMux = intEn_q;
      IDX_INTREQ: rdMux = intReq_q;
      IDX_WTMODE: rdMux = wtMode_q;
      IDX_WTCOUNT: rdMux = count_q[15:8];
      default: rdMux = 8'h00;
    endcase
  endfunction

  // One wait state: ack one cycle after the request, dropped next cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wbReq.cyc & wbReq.stb & ~ack_q;
      rdat_q <= {24'h00_0000, rdMux(idx)};
    end
  end

  assign wbRsp.ack = ack_q;
  assign wbRsp.dat = rdat_q;

  // ************************************************************
  // Status flags and stack pointer
  // ************************************************************
  // Core updates win over a bus write in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= RST_FLAGS;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (aluFlags.upd[b]) begin
          flags_q[b] <= aluFlags.val[b];
        end else if (wr(IDX_FLAGS)) begin
          flags_q[b] <= wdat[b];
        end
      end
    end
  end

  // bit 0 stored as written, software keeps it clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stack_q <= RST_STACK;
    end else if (stackLoad) begin
      stack_q <= stackIn;
    end else if (wr(IDX_STACK)) begin
      stack_q <= wdat;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clkMode_q <= RST_CLKMODE;
      intEn_q <= RST_INTEN;
      wtMode_q <= RST_WTMODE;
      btaBound_q <= RST_BTABOUND;
      xosc_q <= RST_XOSC;
      edgeSel_q <= RST_EDGESEL;
      padie_q <= RST_PADIE;
      pbdie_q <= RST_PBDIE;
    end else begin
      if (wr(IDX_CLKMODE)) begin
        clkMode_q <= wdat;
      end
      // reserved enable bit held at zero
      if (wr(IDX_INTEN)) begin
        intEn_q <= wdat & IRQ_MASK;
      end
      if (wr(IDX_WTMODE)) begin
        wtMode_q <= wdat;
      end
      if (wr(IDX_BTABOUND)) begin
        btaBound_q <= wdat;
      end
      if (wr(IDX_XOSC)) begin
        xosc_q <= wdat & XOSC_MASK;
      end
      if (wr(IDX_EDGESEL)) begin
        edgeSel_q <= wdat & EDGE_MASK;
      end
      if (wr(IDX_PADIE)) begin
        padie_q <= wdat & PADIE_MASK;
      end
      if (wr(IDX_PBDIE)) begin
        pbdie_q <= wdat;
      end
    end
  end

  // ************************************************************
  // Clock and oscillator controls
  // ************************************************************
  clkSel_t clkSel;

  always_comb begin
    clkSel = CLK_NONE;
    if (!clkMode_q[CM_TYPE]) begin
      unique case (clkMode_q[7:5])
        3'h0: clkSel = CLK_FAST_D4;
        3'h1: clkSel = CLK_FAST_D2;
        3'h3: clkSel = CLK_XTAL_D4;
        3'h4: clkSel = CLK_XTAL_D2;
        3'h5: clkSel = CLK_XTAL_D1;
        3'h6: clkSel = CLK_SLOW_D4;
        3'h7: clkSel = CLK_SLOW_D1;
        default: clkSel = CLK_NONE;
      endcase
    end else begin
      unique case (clkMode_q[7:5])
        3'h0: clkSel = CLK_FAST_D16;
        3'h1: clkSel = CLK_FAST_D8;
        3'h2: clkSel = CLK_SLOW_D16;
        3'h3: clkSel = CLK_FAST_D32;
        3'h4: clkSel = CLK_FAST_D64;
        3'h5: clkSel = CLK_XTAL_D8;
        default: clkSel = CLK_NONE;
      endcase
    end
  end

  // Reserved codes give CLK_NONE; the clock tree keeps its last choice
  always_comb begin
    sysCtl.clkSel = clkSel;
    sysCtl.fastOscEn = clkMode_q[CM_FAST_EN];
    sysCtl.slowOscEn = clkMode_q[CM_SLOW_EN];
    sysCtl.wdogRun = clkMode_q[CM_WDOG_EN] & clkMode_q[CM_SLOW_EN];
    sysCtl.resetPinSel = clkMode_q[CM_PIN_SEL];
    sysCtl.xtalOscEn = xosc_q[7];
    sysCtl.xtalDrive = xosc_q[6:5];
    sysCtl.refPowerDown = xosc_q[0];
  end

  // ************************************************************
  // Wide timer
  // ************************************************************
  logic [7:0] pa_q, pb_q;
  logic srcTick, divTick;
  logic [5:0] pre_q;
  logic [15:0] countNext;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pa_q <= 8'h00;
      pb_q <= 8'h00;
    end else begin
      pa_q <= portA;
      pb_q <= portB;
    end
  end

  // source select; 000 and 010 stop the count
  always_comb begin
    unique case (wtMode_q[7:5])
      3'h1: srcTick = 1'b1;
      3'h3: srcTick = pa_q[4] & ~portA[4];
      3'h4: srcTick = fastTick;
      3'h5: srcTick = xtalTick;
      3'h6: srcTick = slowTick;
      3'h7: srcTick = pa_q[0] & ~portA[0];
      default: srcTick = 1'b0;
    endcase
  end

  always_comb begin
    unique case (wtMode_q[4:3])
      2'h0: divTick = srcTick;
      2'h1: divTick = srcTick & (pre_q[1:0] == 2'h3);
      2'h2: divTick = srcTick & (pre_q[3:0] == 4'hF);
      default: divTick = srcTick & (pre_q == 6'h3F);
    endcase
  end

  assign countNext = count_q + 16'h0001;

  // count per divided tick, hold when off
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= 6'h00;
      count_q <= 16'h0000;
    end else if (srcTick) begin
      pre_q <= pre_q + 6'h01;
      if (divTick) begin
        count_q <= countNext;
      end
    end
  end

  logic [3:0] bitSel;
  logic selNow, selNext, wtEvent;
  assign bitSel = {1'b1, wtMode_q[2:0]};
  assign selNow = count_q[bitSel];
  assign selNext = countNext[bitSel];
  assign wtEvent = divTick & (selNow != selNext)
                   & (selNext != edgeSel_q[4]);

  // ************************************************************
  // Pin interrupts and wake-up gating
  // ************************************************************
  function automatic logic edgeHit(input logic [1:0] mode,
                                   input logic prev, input logic now);
    unique case (mode)
      2'h0: edgeHit = prev != now;
      2'h1: edgeHit = ~prev & now;
      2'h2: edgeHit = prev & ~now;
      default: edgeHit = 1'b0;
    endcase
  endfunction

  logic pin1Event, pin2Event;
  // first pair, port A line 0 or port B line 5
  assign pin1Event =
    (padie_q[0] & edgeHit(edgeSel_q[1:0], pa_q[0], portA[0])) |
    (pbdie_q[5] & edgeHit(edgeSel_q[1:0], pb_q[5], portB[5]));
  // second pair, port B line 0 or port A line 4
  assign pin2Event =
    (pbdie_q[0] & edgeHit(edgeSel_q[3:2], pb_q[0], portB[0])) |
    (padie_q[4] & edgeHit(edgeSel_q[3:2], pa_q[4], portA[4]));

  // wake-up on toggle of enabled pins
  assign portAWake = padie_q & (pa_q ^ portA);
  assign portBWake = pbdie_q & (pb_q ^ portB);

  // ************************************************************
  // Interrupt requests
  // ************************************************************
  logic [7:0] events;
  always_comb begin
    events = 8'h00;
    events[IRQ_BTB] = btbEvent;
    events[IRQ_BTA] = btaEvent;
    events[IRQ_CMP] = cmpEvent;
    events[IRQ_ADC] = adcEvent;
    events[IRQ_WT] = wtEvent;
    events[IRQ_PIN2] = pin2Event;
    events[IRQ_PIN1] = pin1Event;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      intReq_q <= RST_INTREQ;
    end else if (wr(IDX_INTREQ)) begin
      intReq_q <= ((intReq_q & wdat) | events) & IRQ_MASK;
    end else begin
      intReq_q <= intReq_q | events;
    end
  end

  assign irq = |(intReq_q & intEn_q);

  assign stackPtr = stack_q;
  assign flagsOut = flags_q[3:0];
  assign portADigEn = padie_q;
  assign portBDigEn = pbdie_q;
  assign btaBound = btaBound_q;
  assign wideCount = count_q;

endmodule

/* test/core_model.sv */
// Partner model: core side adder that pulses flag updates and stack loads.
// Assumes the IO bank samples its strobes on the next sys_clk edge.
`timescale 1ns/1ps
module core_model
  import sysio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic go,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic spGo,
  input wire logic [7:0] spVal,
  output sysio_pkg::aluFlags_t aluFlags,
  output logic stackLoad,
  output logic [7:0] stackIn
);
  logic [8:0] s;
  logic [4:0] h;
  assign s = {1'b0, a} + {1'b0, b};
  assign h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
  // add flags
  // Values invert when no strobe, so a stale value is never trusted
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aluFlags <= '0;
    end else if (go) begin
      aluFlags.upd <= 4'hF;
      aluFlags.val <= {(a[7] == b[7]) && (s[7] != a[7]), h[4], s[8],
        s[7:0] == 8'h00};
    end else begin
      aluFlags.upd <= 4'h0;
      aluFlags.val <= ~aluFlags.val;
    end
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stackLoad <= 1'b0;
      stackIn <= 8'h00;
    end else begin
      stackLoad <= spGo;
      stackIn <= {spVal[7:1], 1'b0};
    end
  end
endmodule

/* test/sys_io_chk.sv */
// Checker: flag loads and register write effects of the IO bank.
// Assumes binding onto sys_io_regs; sees only its ports.
`timescale 1ns/1ps
module sys_io_chk
  import sysio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire sysio_pkg::wbReq_t wbReq,
  input wire sysio_pkg::wbRsp_t wbRsp,
  input wire sysio_pkg::aluFlags_t aluFlags,
  input wire logic [3:0] flagsOut,
  input wire sysio_pkg::sysCtl_t sysCtl,
  input wire logic [7:0] portBDigEn,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic w;
  logic [7:0] ix;
  logic [7:0] d;
  assign w = wbReq.cyc & wbReq.stb & wbReq.we & wbReq.sel[0] & !wbRsp.ack;
  assign ix = wbReq.adr[9:2];
  assign d = wbReq.dat[7:0];
  AST_FLAG_WRAP: assert property (
    aluFlags.upd[3] |=> flagsOut[3] == $past(aluFlags.val[3]))
    else $error("wrap flag not loaded");
  AST_FLAG_ZERO: assert property (
    aluFlags.upd[0] |=> flagsOut[0] == $past(aluFlags.val[0]))
    else $error("zero flag not loaded");
  AST_CLK_BITS: assert property (
    w && ix == IDX_CLKMODE |=> sysCtl.fastOscEn == $past(d[4]) &&
    sysCtl.slowOscEn == $past(d[2]) && sysCtl.resetPinSel == $past(d[0]))
    else $error("clock mode enables wrong");
  AST_WDOG: assert property (
    w && ix == IDX_CLKMODE |=> sysCtl.wdogRun == ($past(d[1]) & $past(d[2])))
    else $error("watchdog run wrong");
  AST_WDOG_GATE: assert property (
    !sysCtl.slowOscEn |-> !sysCtl.wdogRun)
    else $error("watchdog runs without slow oscillator");
  AST_CLK_T0: assert property (
    w && ix == IDX_CLKMODE && d[7:5] == 3'b101 && !d[3]
    |=> sysCtl.clkSel == CLK_XTAL_D1)
    else $error("type 0 crystal code wrong");
  AST_CLK_RSV: assert property (
    w && ix == IDX_CLKMODE && d[7:6] == 2'b11 && d[3]
    |=> sysCtl.clkSel == CLK_NONE)
    else $error("reserved clock code selects a clock");
  AST_XOSC: assert property (
    w && ix == IDX_XOSC |=> sysCtl.xtalOscEn == $past(d[7]) &&
    sysCtl.xtalDrive == $past(d[6:5]))
    else $error("crystal control wrong");
  AST_PBDIE: assert property (
    w && ix == IDX_PBDIE |=> portBDigEn == $past(d))
    else $error("port B enables wrong");
  AST_IRQ_OFF: assert property (
    w && ix == IDX_INTEN && d == 8'h00 |=> !irq [*2])
    else $error("irq with all enables clear");
endmodule
bind sys_io_regs sys_io_chk u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .wbReq(wbReq), .wbRsp(wbRsp), .aluFlags(aluFlags), .flagsOut(flagsOut),
  .sysCtl(sysCtl), .portBDigEn(portBDigEn), .irq(irq));

/* test/tb.sv */
// Testbench: drives the IO bank over Wishbone and through a core model.
// Assumes sys_io_regs, core_model and the bound checker are compiled.
`timescale 1ns/1ps
module tb;
  import sysio_pkg::*;
  logic sys_clk;
  logic arst_n;
  wbReq_t wbReq;
  wbRsp_t wbRsp;
  aluFlags_t aluFlags;
  sysCtl_t sysCtl;
  logic go, spGo, stackLoad, irq;
  logic [7:0] a, b, spVal, stackIn, stackPtr, portA, portB, paEn, pbEn, bnd;
  logic [3:0] flagsOut, evt;
  logic [2:0] tk;
  logic [7:0] aWake, bWake;
  logic [15:0] wideCount, w0;
  logic [7:0] x;
  int compares, n_mismatch;
  logic [7:0] ri [12] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h09, 8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h01};
  clkSel_t cs [16] = '{CLK_FAST_D4, CLK_FAST_D2, CLK_NONE, CLK_XTAL_D4,
    CLK_XTAL_D2, CLK_XTAL_D1, CLK_SLOW_D4, CLK_SLOW_D1, CLK_FAST_D16,
    CLK_FAST_D8, CLK_SLOW_D16, CLK_FAST_D32, CLK_FAST_D64, CLK_XTAL_D8,
    CLK_NONE, CLK_NONE};
  int ib [4] = '{6, 7, 4, 3};
  logic [7:0] ae [4] = '{8'h7F, 8'hFF, 8'h80, 8'h0F};
  logic [7:0] be [4] = '{8'h01, 8'h01, 8'h80, 8'h01};
  logic [3:0] fe [4] = '{4'hC, 4'h7, 4'hB, 4'h4};
  // Bit 1 is the rise expectation, bit 0 the fall expectation
  logic [1:0] pe [3] = '{2'b11, 2'b10, 2'b01};

  sys_io_regs dut (.sys_clk(sys_clk), .arst_n(arst_n), .wbReq(wbReq),
    .wbRsp(wbRsp), .aluFlags(aluFlags), .stackIn(stackIn),
    .stackLoad(stackLoad), .stackPtr(stackPtr), .flagsOut(flagsOut),
    .portA(portA), .portB(portB), .fastTick(tk[0]), .xtalTick(tk[1]),
    .slowTick(tk[2]), .btaEvent(evt[0]), .btbEvent(evt[1]),
    .cmpEvent(evt[2]), .adcEvent(evt[3]), .sysCtl(sysCtl),
    .portADigEn(paEn), .portBDigEn(pbEn), .portAWake(aWake),
    .portBWake(bWake),
    .btaBound(bnd), .wideCount(wideCount), .irq(irq));
  core_model core (.sys_clk(sys_clk), .arst_n(arst_n), .go(go), .a(a),
    .b(b), .spGo(spGo), .spVal(spVal), .aluFlags(aluFlags),
    .stackLoad(stackLoad), .stackIn(stackIn));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task results;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task ck(string nm, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until the edge that sees ack high
  task wbx(logic we, logic [7:0] ix, logic [7:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    wbReq <= '{1'b1, 1'b1, we, 4'h1, {ix, 2'b00}, {24'h0, wd}};
    // Ack is read at the edge itself, before that edge updates it
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 40);
    if (wbRsp.ack !== 1'b1) begin
      n_mismatch++;
      results();
    end
    x = wbRsp.dat[7:0];
    // Released at the ack edge, so the slave never takes it twice
    wbReq <= '0;
  endtask
  task wr(logic [7:0] ix, logic [7:0] d);
    wbx(1'b1, ix, d);
  endtask
  task rd(string nm, logic [7:0] ix, logic [7:0] e);
    wbx(1'b0, ix, 8'h00);
    ck(nm, e, x);
  endtask
  // Lines 0..7 are port A, 8..15 port B; ew is the expected wake pulse
  task pin(int k, logic v, logic [15:0] ew);
    @(posedge sys_clk);
    if (k < 8) begin
      portA[k] <= v;
    end else begin
      portB[k - 8] <= v;
    end
    @(posedge sys_clk);
    ck("wake", ew, {bWake, aWake});
    repeat (2) @(posedge sys_clk);
  endtask
  task pulse(int i);
    @(posedge sys_clk);
    evt <= 4'h1 << i;
    @(posedge sys_clk);
    evt <= 4'h0;
    #1;
  endtask

  initial begin
    {arst_n, go, spGo, a, b, spVal, portA, portB, evt, tk} = '0;
    wbReq = '0;
    compares = 0;
    n_mismatch = 0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      rd("reset read", ri[i], (i == 2) ? 8'hF6 : 8'h00);
    end
    ck("portB enables", 8'hFF, pbEn);
    ck("portA enables", 8'hF9, paEn);
    ck("clock select", CLK_SLOW_D1, sysCtl.clkSel);
    ck("reset bits", 4'hE, {sysCtl.fastOscEn, sysCtl.slowOscEn,
      sysCtl.wdogRun, sysCtl.resetPinSel});
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      {go, a, b} <= {1'b1, ae[i], be[i]};
      @(posedge sys_clk);
      go <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rd("flags", IDX_FLAGS, {4'h0, fe[i]});
      ck("flag port", fe[i], flagsOut);
    end
    wr(IDX_FLAGS, 8'h05);
    rd("flags written", IDX_FLAGS, 8'h05);
    @(posedge sys_clk);
    {spGo, spVal} <= {1'b1, 8'h35};
    @(posedge sys_clk);
    spGo <= 1'b0;
    rd("stack load", IDX_STACK, 8'h34);
    ck("stack port", 8'h34, stackPtr);
    $display("test core done");
    for (int i = 0; i < 16; i++) begin
      wr(IDX_CLKMODE, {i[2:0], i[0], i[3], i[1], 1'b1, i[2]});
      ck("clock select", cs[i], sysCtl.clkSel);
      ck("clock enables", {i[0], i[1], i[1], i[2]}, {sysCtl.fastOscEn,
        sysCtl.slowOscEn, sysCtl.wdogRun, sysCtl.resetPinSel});
    end
    wr(IDX_CLKMODE, 8'hF6);
    $display("test clock done");
    for (int i = 0; i < 4; i++) begin
      wr(IDX_INTEN, 8'h00);
      pulse(i);
      ck("irq masked", 1'b0, irq);
      wr(IDX_INTEN, 8'h01 << ib[i]);
      ck("irq", 1'b1, irq);
      rd("request", IDX_INTREQ, 8'h01 << ib[i]);
      wr(IDX_INTREQ, 8'h00);
      ck("irq cleared", 1'b0, irq);
    end
    wr(IDX_INTEN, 8'hFF);
    rd("enable mask", IDX_INTEN, 8'hDF);
    wr(IDX_INTEN, 8'h03);
    for (int i = 0; i < 3; i++) begin
      wr(IDX_EDGESEL, i[7:0]);
      for (int v = 1; v >= 0; v--) begin
        pin(0, v[0], 16'h0001);
        rd("pin edge", IDX_INTREQ, {7'h0, pe[i][v]});
        wr(IDX_INTREQ, 8'h00);
      end
    end
    wr(IDX_EDGESEL, 8'h08);
    pin(4, 1'b1, 16'h0010);
    rd("second pin rise", IDX_INTREQ, 8'h00);
    pin(4, 1'b0, 16'h0010);
    rd("second pin fall", IDX_INTREQ, 8'h02);
    wr(IDX_PADIE, 8'hF8);
    wr(IDX_EDGESEL, 8'h00);
    wr(IDX_INTREQ, 8'h00);
    pin(0, 1'b1, 16'h0000);
    rd("gated pin", IDX_INTREQ, 8'h00);
    $display("test interrupts done");
    wr(IDX_WTMODE, 8'h20);
    repeat (300) @(posedge sys_clk);
    rd("timer request", IDX_INTREQ, 8'h04);
    ck("timer bit 8", 1'b1, wideCount[8]);
    wr(IDX_WTMODE, 8'h00);
    w0 = wideCount;
    repeat (10) @(posedge sys_clk);
    ck("timer held", w0, wideCount);
    // Count now sits between 256 and 511: bit 8 falls at 512
    wr(IDX_INTREQ, 8'h00);
    wr(IDX_EDGESEL, 8'h10);
    wr(IDX_WTMODE, 8'h28);
    w0 = wideCount;
    repeat (40) @(posedge sys_clk);
    ck("prescale four", w0 + 16'h000A, wideCount);
    repeat (840) @(posedge sys_clk);
    rd("timer fall", IDX_INTREQ, 8'h04);
    // Only the selected oscillator tick may advance the count
    for (int j = 0; j < 3; j++) begin
      wr(IDX_WTMODE, {3'(j + 4), 5'h00});
      w0 = wideCount;
      @(posedge sys_clk);
      tk <= ~(3'h1 << j);
      repeat (3) @(posedge sys_clk);
      tk <= 3'h1 << j;
      repeat (5) @(posedge sys_clk);
      tk <= 3'h0;
      @(posedge sys_clk);
      ck("tick source", w0 + 16'h0005, wideCount);
    end
    wr(IDX_WTMODE, 8'h00);
    rd("count high", IDX_WTCOUNT, 8'h02);
    $display("test timer done");
    wr(IDX_XOSC, 8'hC1);
    ck("crystal", 4'hD, {sysCtl.xtalOscEn, sysCtl.xtalDrive,
      sysCtl.refPowerDown});
    rd("crystal read", IDX_XOSC, 8'h00);
    wr(IDX_PBDIE, 8'h5A);
    ck("portB enables", 8'h5A, pbEn);
    wr(IDX_INTREQ, 8'h00);
    pin(13, 1'b1, 16'h0000);
    rd("portB gated", IDX_INTREQ, 8'h00);
    pin(9, 1'b1, 16'h0200);
    wr(IDX_BTABOUND, 8'hA5);
    ck("bound", 8'hA5, bnd);
    wr(8'h07, 8'hAA);
    rd("unmapped", 8'h07, 8'h00);
    $display("test registers done");
    results();
  end
endmodule
